// ### rtl/lbs_pkg.sv
// lbs_pkg: constants shared by the local bus slave port
package lbs_pkg;

  // =====================================================================
  // address map
  localparam logic [15:0] BASE_MP      = 16'h1000;
  localparam logic [15:0] BASE_L0      = 16'h2000;
  localparam logic [15:0] BASE_L1      = 16'h3000;
  localparam logic [15:0] BASE_FE      = 16'h4000;
  localparam logic [11:0] BASE_MASK_LO = 12'hFFF;  // each device owns a 4 KB window
  localparam logic [11:0] OFS_BUILD_STAMP = 12'hFC;
  localparam logic [11:0] OFS_SCRATCH     = 12'h00;
  localparam logic [11:0] OFS_STATUS      = 12'h04;

  // =====================================================================
  // reset values and build stamp digits
  localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
  localparam logic [31:0] BUILD_STAMP_DEF = 32'd2000010100;  // arbitrary build stamp

  // =====================================================================
  // hardware settings port
  localparam int HW_RESET_BIT = 7;

  // =====================================================================
  // bus state machine
  typedef enum logic [2:0] {
    LBS_IDLE = 3'b001,
    LBS_DATA = 3'b010,
    LBS_SKIP = 3'b100
  } lbs_state_t;

endpackage

// ### rtl/lbs_sync.sv
// lbs_sync: two flip-flop synchroniser for a bundle of levels
`timescale 1ns/100ps
module lbs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // first stage is read by the second stage only
  always_comb begin
    meta_nxt = ce ? d : meta_r;
    q_nxt    = ce ? meta_r : q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule // lbs_sync

// ### rtl/lbs_clkdiv.sv
// lbs_clkdiv: halves the system clock to make the bus clock
`timescale 1ns/100ps
module lbs_clkdiv (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // divided clock
  output logic      clk_half
);
  logic half_nxt;

  // toggle flop keeps the bus clock phase-locked to the system clock
  always_comb begin
    half_nxt = ce ? ~clk_half : clk_half;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_half <= 1'b0;
    end else begin
      clk_half <= half_nxt;
    end
  end
endmodule // lbs_clkdiv

// ### rtl/local_bus_slave_port.sv
// local_bus_slave_port: multiplexed address/data local bus slave with build stamp register
`timescale 1ns/100ps
module local_bus_slave_port #(
  parameter logic [15:0] BASE_ADDR   = lbs_pkg::BASE_MP,
  parameter logic [31:0] BUILD_STAMP = lbs_pkg::BUILD_STAMP_DEF
) (
  // system clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // hardware settings port
  input  wire logic [7:0]  HW_SETTINGS,
  input  wire logic        HW_SETTINGS_VALID,
  // bus clock out
  output logic             BUS_CLOCK_OUT,
  // local bus from master
  input  wire logic        BUS_RESET_N,
  input  wire logic        BUS_CLOCK_IN,
  input  wire logic [31:0] MUXED_ADDR_DATA_I,
  output logic      [31:0] MUXED_ADDR_DATA_O,
  output logic             MUXED_ADDR_DATA_OE,
  input  wire logic        ADDR_STROBE_N,
  input  wire logic        WRITE_NOT_READ,
  input  wire logic        MASTER_WAIT_N,
  input  wire logic        LAST_TRANSFER_N,
  output logic             SLAVE_READY_N,
  output logic             SLAVE_READY_OE,
  output logic             BURST_TERMINATE_N,
  output logic             BURST_TERMINATE_OE,
  // user side
  output logic      [31:0] SCRATCH,
  output logic             SYS_RESET
);

  // =====================================================================
  // bus clock generation
  logic clk_half;

  lbs_clkdiv u_div (
    .clk      (CLK),
    .rst_n    (RST_N),
    .ce       (CE),
    .clk_half (clk_half)
  );

  // =====================================================================
  // input synchronisers: bus pins and bus clock come from outside
  localparam int SW = 32 + 6 + 9;
  logic [SW-1:0] sync_in;
  logic [SW-1:0] sync_out;
  logic [31:0]   ad_s;
  logic          ads_n_s;
  logic          wnr_s;
  logic          wait_n_s;
  logic          last_n_s;
  logic          lrst_n_s;
  logic          bus_clock_out_s;
  logic [7:0]    hw_s;
  logic          hw_v_s;

  assign sync_in = {MUXED_ADDR_DATA_I, ADDR_STROBE_N, WRITE_NOT_READ, MASTER_WAIT_N,
                    LAST_TRANSFER_N, BUS_RESET_N, BUS_CLOCK_IN, HW_SETTINGS,
                    HW_SETTINGS_VALID};

  lbs_sync #(.W(SW)) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .d     (sync_in),
    .q     (sync_out)
  );

  assign {ad_s, ads_n_s, wnr_s, wait_n_s, last_n_s, lrst_n_s, bus_clock_out_s, hw_s, hw_v_s} = sync_out;

  // =====================================================================
  // system reset from hardware settings bit 7
  logic sysrst_r;
  logic sysrst_nxt;
  logic bus_clock_out_d_r;
  logic bus_clock_out_d_nxt;
  logic bus_clock_out_rise;

  // reset is on after power-up until software clears the setting bit
  always_comb begin
    sysrst_nxt = sysrst_r;
    if (hw_v_s) begin
      sysrst_nxt = hw_s[lbs_pkg::HW_RESET_BIT];
    end
    bus_clock_out_d_nxt = bus_clock_out_s;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sysrst_r <= 1'b1;
      bus_clock_out_d_r <= 1'b0;
    end else if (CE) begin
      sysrst_r <= sysrst_nxt;
      bus_clock_out_d_r <= bus_clock_out_d_nxt;
    end
  end

  // bus signals are sampled on the rising edge of the bus clock
  assign bus_clock_out_rise = bus_clock_out_s & ~bus_clock_out_d_r;

  // =====================================================================
  // bus state machine and registers
  lbs_pkg::lbs_state_t st_r;
  lbs_pkg::lbs_state_t st_nxt;
  logic [13:0] waddr_r;
  logic [13:0] waddr_nxt;
  logic        wr_r;
  logic        wr_nxt;
  logic [31:0] scratch_r;
  logic [31:0] scratch_nxt;
  logic [31:0] dout_r;
  logic [31:0] dout_nxt;
  logic        oe_r;
  logic        oe_nxt;
  logic        rdy_n_r;
  logic        rdy_n_nxt;
  logic        rdy_oe_r;
  logic        rdy_oe_nxt;
  logic        hit_strobe;
  logic [11:0] ofs;
  logic [31:0] rd_data;
  logic        soft_rst;

  // either reset source holds the interface idle
  assign soft_rst = sysrst_r | ~lrst_n_s;

  // own window: upper address nibble matches base, lines 1..0 not carried
  assign hit_strobe = ({ad_s[15:12], 12'h000} == BASE_ADDR);
  assign ofs        = {waddr_r[9:0], 2'b00};

  // read mux; unmapped offsets inside the window read zero
  always_comb begin
    case (ofs)
      lbs_pkg::OFS_BUILD_STAMP: rd_data = BUILD_STAMP;
      lbs_pkg::OFS_SCRATCH:     rd_data = scratch_r;
      lbs_pkg::OFS_STATUS:      rd_data = {31'h0, sysrst_r};
      default:                  rd_data = 32'h0000_0000;
    endcase
  end

  // one data beat per bus clock once wait is released
  always_comb begin
    st_nxt      = st_r;
    waddr_nxt   = waddr_r;
    wr_nxt      = wr_r;
    scratch_nxt = scratch_r;
    dout_nxt    = dout_r;
    oe_nxt      = oe_r;
    rdy_n_nxt   = 1'b1;
    rdy_oe_nxt  = rdy_oe_r;
    if (bus_clock_out_rise) begin
      case (st_r)
        lbs_pkg::LBS_IDLE: begin
          oe_nxt     = 1'b0;
          rdy_oe_nxt = 1'b0;
          if (!ads_n_s) begin
            waddr_nxt = ad_s[15:2];
            wr_nxt    = wnr_s;
            st_nxt    = hit_strobe ? lbs_pkg::LBS_DATA : lbs_pkg::LBS_SKIP;
          end
        end
        lbs_pkg::LBS_DATA: begin
          rdy_oe_nxt = 1'b1;
          if (wait_n_s) begin
            if (wr_r) begin
              if (ofs == lbs_pkg::OFS_SCRATCH) begin
                scratch_nxt = ad_s;
              end
              oe_nxt = 1'b0;
            end else begin
              dout_nxt = rd_data;
              oe_nxt   = 1'b1;
            end
            rdy_n_nxt = 1'b0;
            waddr_nxt = waddr_r + 14'h1;
            if (!last_n_s) begin
              st_nxt = lbs_pkg::LBS_IDLE;
            end
          end
        end
        lbs_pkg::LBS_SKIP: begin
          // foreign access: stay off the lines until its last beat
          oe_nxt     = 1'b0;
          rdy_oe_nxt = 1'b0;
          if (wait_n_s && !last_n_s) begin
            st_nxt = lbs_pkg::LBS_IDLE;
          end
        end
        default: st_nxt = lbs_pkg::LBS_IDLE;
      endcase
    end else begin
      rdy_n_nxt = rdy_n_r;  // ready holds for the whole bus clock
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r      <= lbs_pkg::LBS_IDLE;
      waddr_r   <= 14'h0000;
      wr_r      <= 1'b0;
      scratch_r <= lbs_pkg::SCRATCH_RST;
      dout_r    <= 32'h0000_0000;
      oe_r      <= 1'b0;
      rdy_n_r   <= 1'b1;
      rdy_oe_r  <= 1'b0;
    end else if (CE) begin
      if (soft_rst) begin
        st_r      <= lbs_pkg::LBS_IDLE;
        waddr_r   <= 14'h0000;
        wr_r      <= 1'b0;
        scratch_r <= lbs_pkg::SCRATCH_RST;
        dout_r    <= 32'h0000_0000;
        oe_r      <= 1'b0;
        rdy_n_r   <= 1'b1;
        rdy_oe_r  <= 1'b0;
      end else begin
        st_r      <= st_nxt;
        waddr_r   <= waddr_nxt;
        wr_r      <= wr_nxt;
        scratch_r <= scratch_nxt;
        dout_r    <= dout_nxt;
        oe_r      <= oe_nxt;
        rdy_n_r   <= rdy_n_nxt;
        rdy_oe_r  <= rdy_oe_nxt;
      end
    end
  end

  // =====================================================================
  // outputs straight from flip-flops, except BURST_TERMINATE_N which is tied high
  // terminate is never used: the slave accepts bursts of any length
  assign BUS_CLOCK_OUT      = clk_half;
  assign MUXED_ADDR_DATA_O  = dout_r;
  assign MUXED_ADDR_DATA_OE = oe_r;
  assign SLAVE_READY_N      = rdy_n_r;
  assign SLAVE_READY_OE     = rdy_oe_r;
  assign BURST_TERMINATE_N  = rdy_oe_r ? 1'b1 : 1'b1;
  assign BURST_TERMINATE_OE = rdy_oe_r;
  assign SCRATCH            = scratch_r;
  assign SYS_RESET          = sysrst_r;

endmodule // local_bus_slave_port

// ### testbench/lbs_checker.sv
// lbs_checker: pin-level assertions for the local bus slave port
`timescale 1ns/100ps
module lbs_checker (
  // clock, resets and settings
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        BUS_RESET_N,
  input wire logic [7:0]  HW_SETTINGS,
  input wire logic        HW_SETTINGS_VALID,
  input wire logic        SYS_RESET,
  // bus pins
  input wire logic        BUS_CLOCK_IN,
  input wire logic        BUS_CLOCK_OUT,
  input wire logic        WRITE_NOT_READ,
  input wire logic        MASTER_WAIT_N,
  input wire logic        LAST_TRANSFER_N,
  input wire logic        MUXED_ADDR_DATA_OE,
  input wire logic        SLAVE_READY_N,
  input wire logic        SLAVE_READY_OE,
  input wire logic        BURST_TERMINATE_N,
  input wire logic        BURST_TERMINATE_OE,
  // user side
  input wire logic [31:0] SCRATCH
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // =====
  // bus timing
  a_clk_half_rate: assert property ($rose(BUS_CLOCK_OUT) |=> !BUS_CLOCK_OUT ##1 BUS_CLOCK_OUT)
    else $error("bus clock out not half rate");
  a_term_stays_off: assert property (BURST_TERMINATE_N && BURST_TERMINATE_OE == SLAVE_READY_OE)
    else $error("terminate misbehaves");
  a_ready_is_driven: assert property (!SLAVE_READY_N |-> SLAVE_READY_OE)
    else $error("ready low while undriven");
  // wait pin is caught by the first sync stage three clocks ahead of the ready fall
  a_ready_after_wait: assert property ($fell(SLAVE_READY_N) |->
    $past(MASTER_WAIT_N, 3) && $past(BUS_CLOCK_IN, 2))
    else $error("ready during wait");
  a_ready_one_beat: assert property ($fell(SLAVE_READY_N) && !LAST_TRANSFER_N |=>
    !SLAVE_READY_N [*6] ##[1:3] SLAVE_READY_N)
    else $error("ready not one bus clock");
  a_drive_read_only: assert property (MUXED_ADDR_DATA_OE |-> !WRITE_NOT_READ)
    else $error("data driven on write");
  // =====
  // resets
  a_sysrst_idle: assert property (SYS_RESET [*3] |-> SLAVE_READY_N && SCRATCH == 32'h0)
    else $error("active under system reset");
  a_busrst_clear: assert property (!BUS_RESET_N [*4] |-> SCRATCH == 32'h0 && !MUXED_ADDR_DATA_OE)
    else $error("bus reset not clearing");
  a_sysrst_follow: assert property ((HW_SETTINGS_VALID && HW_SETTINGS[7]) [*4] |-> SYS_RESET)
    else $error("system reset not set");
  c_read_beat: cover property ($fell(SLAVE_READY_N) && !WRITE_NOT_READ);
  c_write_beat: cover property ($fell(SLAVE_READY_N) && WRITE_NOT_READ);
  c_sysrst_drop: cover property ($fell(SYS_RESET));
endmodule // lbs_checker

bind local_bus_slave_port lbs_checker lbs_checker_i (.*);

// ### testbench/lbs_bus_master.sv
// lbs_bus_master: bus master model for the multiplexed local bus
`timescale 1ns/100ps
module lbs_bus_master (
  // bus outputs
  output logic        bclk,
  output logic        strobe_n,
  output logic        wnr,
  output logic        wait_n,
  output logic        last_n,
  output logic [31:0] ad,
  // resolved lines
  input  wire logic [31:0] ad_w,
  input  wire logic        rdy_w
);
  int          nrdy;
  logic [31:0] rd [2];
  // free running bus clock, phase unrelated to the system clock
  initial begin
    {strobe_n, wnr, wait_n, last_n, ad} = {4'hB, 32'h0};
    bclk = 1'b0;
    #37;
    forever #200 bclk = ~bclk;
  end
  // one access; released data lines show the inverse so stale values never match
  task automatic xfer(input logic we, input logic [15:0] a, input logic [31:0] wd,
                      input int nb, input int nw);
    nrdy = 0;
    @(posedge bclk) #5;
    {strobe_n, wnr, ad} = {1'b0, we, 16'h0000, a};
    @(posedge bclk) #5;
    strobe_n = 1'b1;
    wait_n = (nw == 0);
    last_n = (nb != 1);
    ad = we ? wd : ~ad;
    repeat (nb + nw + 3) begin
      @(posedge bclk);
      if (wait_n && !rdy_w && nrdy < nb) begin
        rd[nrdy] = ad_w;
        nrdy++;
      end
      #5;
      nw = (nw > 0) ? nw - 1 : 0;
      wait_n = (nw == 0);
      last_n = (nrdy != nb - 1);
      if (nrdy == nb) break;
    end
    {last_n, ad} = {1'b1, ~ad};
  endtask
endmodule // lbs_bus_master

// ### testbench/tb.sv
// tb: self-checking bench for the local bus slave port
`timescale 1ns/100ps
module tb;
  localparam logic [31:0] STAMP = 32'd2024123123;  // arbitrary build stamp
  logic        CLK, RST_N, CE, HW_SETTINGS_VALID, BUS_RESET_N, BUS_CLOCK_IN;
  logic        ADDR_STROBE_N, WRITE_NOT_READ, MASTER_WAIT_N, LAST_TRANSFER_N;
  logic [7:0]  HW_SETTINGS;
  logic [31:0] ad_m, MUXED_ADDR_DATA_I, MUXED_ADDR_DATA_O, SCRATCH;
  logic        MUXED_ADDR_DATA_OE, SLAVE_READY_N, SLAVE_READY_OE, rdy_w;
  logic        BURST_TERMINATE_N, BURST_TERMINATE_OE, SYS_RESET, BUS_CLOCK_OUT;
  int          errors, checked;
  // wire levels: slave wins when enabled; ready line has a pull-up
  assign MUXED_ADDR_DATA_I = MUXED_ADDR_DATA_OE ? MUXED_ADDR_DATA_O : ad_m;
  assign rdy_w = SLAVE_READY_OE ? SLAVE_READY_N : 1'b1;
  local_bus_slave_port #(.BASE_ADDR(lbs_pkg::BASE_L1), .BUILD_STAMP(STAMP))
    local_bus_slave_port_i (.*);
  lbs_bus_master lbs_bus_master_i (.bclk(BUS_CLOCK_IN), .strobe_n(ADDR_STROBE_N),
    .wnr(WRITE_NOT_READ), .wait_n(MASTER_WAIT_N), .last_n(LAST_TRANSFER_N),
    .ad(ad_m), .ad_w(MUXED_ADDR_DATA_I), .rdy_w(rdy_w));
  // =====
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic we, input logic [15:0] a, input logic [31:0] wd,
                    input int nb, input int nw);
    lbs_bus_master_i.xfer(we, a, wd, nb, nw);
  endtask
  task print_verdict;
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // =====
  // scenarios
  task automatic t_sys_reset;
    chk(SYS_RESET, 1'b1);
    xf(1'b1, 16'h3000, 32'h1234_5678, 1, 0);
    chk(lbs_bus_master_i.nrdy, 0);
    @(posedge CLK) #5;
    {HW_SETTINGS_VALID, HW_SETTINGS} = {1'b1, 8'h00};
    repeat (5) @(posedge CLK);
    chk(SYS_RESET, 1'b0);
  endtask
  task automatic t_regs;
    xf(1'b1, 16'h3000, 32'hCAFE_F00D, 1, 0);
    chk(SCRATCH, 32'hCAFE_F00D);
    xf(1'b0, 16'h3000, 32'h0, 1, 0);
    chk(lbs_bus_master_i.rd[0], 32'hCAFE_F00D);
    xf(1'b1, 16'h30FC, 32'h0, 1, 0);
    xf(1'b0, 16'h30FC, 32'h0, 1, 0);
    chk(lbs_bus_master_i.rd[0], STAMP);
    xf(1'b0, 16'h3080, 32'hFFFF_FFFF, 1, 0);
    chk(lbs_bus_master_i.rd[0], 32'h0);
  endtask
  // burst with wait states walks from scratch to status
  task automatic t_burst;
    xf(1'b0, 16'h3000, 32'h0, 2, 2);
    chk(lbs_bus_master_i.nrdy, 2);
    chk(lbs_bus_master_i.rd[0], 32'hCAFE_F00D);
    chk(lbs_bus_master_i.rd[1] & 32'h1, 32'h0);
  endtask
  task automatic t_foreign;
    xf(1'b1, 16'h1000, 32'h0BAD_0BAD, 1, 0);
    chk(lbs_bus_master_i.nrdy, 0);
    xf(1'b0, 16'h10FC, 32'h0, 1, 0);
    chk(lbs_bus_master_i.nrdy, 0);
    chk(SCRATCH, 32'hCAFE_F00D);
  endtask
  task automatic t_resets;
    @(posedge CLK) #5;
    BUS_RESET_N = 1'b0;
    repeat (5) @(posedge CLK);
    chk(SCRATCH, 32'h0);
    #5 BUS_RESET_N = 1'b1;
    xf(1'b1, 16'h3000, 32'h5A5A_A5A5, 1, 0);
    chk(SCRATCH, 32'h5A5A_A5A5);
    @(posedge CLK) #5;
    HW_SETTINGS = 8'h80;
    repeat (5) @(posedge CLK);
    chk(SYS_RESET, 1'b1);
    chk(SCRATCH, 32'h0);
  endtask
  // =====
  // clock, sequence and watchdog
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  initial begin
    {RST_N, CE, BUS_RESET_N} = 3'b011;
    {HW_SETTINGS_VALID, HW_SETTINGS} = {1'b0, 8'h80};
    errors = 0;
    checked = 0;
    repeat (3) @(posedge CLK);
    #5 RST_N = 1'b1;
    t_sys_reset();
    t_regs();
    t_burst();
    t_foreign();
    t_resets();
    print_verdict();
  end
  // generous margin over some ten accesses of a few bus clocks each
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule // tb
